// File: core/pin_level_port_gpio.sv
/*
 * eight-pin bidirectional port with analog select, oscillator-shared top
 * pins and capture / encoder feeds. assumes pins are asynchronous to clk,
 * a single-cycle strobe register master and a board-level tristate resolver.
 */
// Chosen here: the address-and-strobe port and the placing of the registers.
// Summary of operation
// - eight bidirectional pins, each with direction, latch and pin-read bit
// - direction bit one releases the driver, pin is an input
// - direction bit zero drives the latch value onto the pin
// - pin-level register reads pin levels; writes go to the latch
// - latch register reads return latched values, not pin levels
// - oscillator selection in a config register decides top two pins' use
// - top pins not in port use read zero in all three registers
// - low analog-select bits choose converter use of pins zero to five
// - after reset the analog-capable pins are analog inputs
// - direction still rules drivers on analog pins; software keeps them one
// - digital input path off while a pin's analog input is selected
// - output path drives latch regardless of analog select
// - pins two to four feed capture and encoder inputs
// - capture and encoder feeds off while the pin is analog
// - pin six outputs cycle clock in rc, first internal, external clock
// - pin six is port i/o only in the three with-io modes
// - pin seven is never port i/o in external oscillator modes
// - direction bits ignored on pins six and seven in oscillator use
`timescale 1ns/1ps

module pin_level_port_gpio
    import pin_level_port_pkg::*;
#(
    parameter int unsigned width = port_width
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [addr_width-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // pins
    input wire logic [width-1:0] pin_in,
    output logic [width-1:0] pin_out,
    output logic [width-1:0] pin_oe,
    // peripheral feeds
    output periph_in_s periph_in,
    // oscillator pin ownership
    output logic cycle_clock_out,
    output logic osc_pins_owned
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [7:0] sel_mask(input logic [7:0] low, input logic [7:0] high);
        logic [7:0] m;
        m = 8'h00;
        m[3:0] = low[3:0];
        m[5] = low[5];
        m[4] = low[4];
        return m & analog_pin_mask;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] output_latch;
    logic [7:0] direction_control;
    logic [7:0] analog_select_low;
    logic [7:0] analog_select_high;
    osc_mode_e osc_mode;
    logic [7:0] pin_sync1;
    logic [7:0] pin_sync2;
    logic [1:0] cycle_div;
    logic [7:0] port_mask;
    logic [7:0] analog_sel;
    logic [7:0] digital_in;
    logic pin6_io;
    logic pin7_io;
    logic pin6_clk;

    // oscillator-driven ownership of the top pins
    always_comb begin
        pin6_io = (osc_mode == rc_osc_with_io) || (osc_mode == internal_osc_with_io)
                  || (osc_mode == ext_clock_with_io);
        pin6_clk = (osc_mode == rc_osc_mode) || (osc_mode == internal_osc_clkout)
                   || (osc_mode == ext_clock_mode);
        // pin seven is only free when no external oscillator or clock uses it
        pin7_io = (osc_mode == internal_osc_clkout)
                  || (osc_mode == internal_osc_with_io);
        port_mask = {pin7_io, pin6_io, 6'h3f};
    end

    assign osc_pins_owned = ~(pin6_io & pin7_io);

    // analog select: one selects analog
    assign analog_sel = sel_mask(analog_select_low, analog_select_high);

    // two-stage synchroniser; only the second stage is used
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_sync1 <= 8'h00;
            pin_sync2 <= 8'h00;
        end else begin
            pin_sync1 <= pin_in;
            pin_sync2 <= pin_sync1;
        end
    end

    // digital input blanked on analog pins and non-port top pins
    assign digital_in = pin_sync2 & ~analog_sel & port_mask;

    // latch: written through either the pin-level or the latch address
    always_ff @(posedge clk) begin
        if (!nrst) begin
            output_latch <= output_latch_rst;
        end else if (reg_wr && (reg_addr == pin_level_port_addr
                                || reg_addr == output_latch_addr)) begin
            output_latch <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            direction_control <= direction_control_rst;
        end else if (reg_wr && reg_addr == direction_control_addr) begin
            direction_control <= reg_wdata;
        end
    end

    // analog pins come up analog
    always_ff @(posedge clk) begin
        if (!nrst) begin
            analog_select_low <= analog_select_low_rst;
            analog_select_high <= analog_select_high_rst;
        end else if (reg_wr && reg_addr == analog_select_low_addr) begin
            analog_select_low <= reg_wdata & analog_low_used;
        end else if (reg_wr && reg_addr == analog_select_high_addr) begin
            analog_select_high <= reg_wdata & analog_high_used;
        end
    end

    // unknown codes leave the current selection in place
    always_ff @(posedge clk) begin
        if (!nrst) begin
            osc_mode <= osc_mode_e'(osc_config_rst);
        end else if (reg_wr && reg_addr == osc_config_addr) begin
            if (reg_wdata[3:0] <= 4'h9) begin
                osc_mode <= osc_mode_e'(reg_wdata[3:0]);
            end
        end
    end

    // cycle clock: oscillator taken as clk, divided by four
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cycle_div <= 2'h0;
            cycle_clock_out <= 1'b0;
        end else begin
            cycle_div <= cycle_div + 2'h1;
            if (cycle_div == cycle_div_last || cycle_div == 2'h1) begin
                cycle_clock_out <= ~cycle_clock_out;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers

    // direction rules drivers even on analog pins
    always_comb begin
        pin_out = output_latch;
        pin_oe = ~direction_control & port_mask;
        if (pin6_clk) begin
            pin_out[6] = cycle_clock_out;
            pin_oe[6] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // peripheral feeds, silenced on analog pins

    always_ff @(posedge clk) begin
        if (!nrst) begin
            periph_in <= '0;
        end else begin
            periph_in.capture_in_one <= digital_in[cap_one_pin];
            periph_in.encoder_index_in <= digital_in[cap_one_pin];
            periph_in.capture_in_two <= digital_in[cap_two_pin];
            periph_in.encoder_chan_a <= digital_in[cap_two_pin];
            periph_in.capture_in_three <= digital_in[cap_three_pin];
            periph_in.encoder_chan_b <= digital_in[cap_three_pin];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, one cycle after the strobe

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                pin_level_port_addr: reg_rdata <= digital_in;
                output_latch_addr: reg_rdata <= output_latch & port_mask;
                direction_control_addr: reg_rdata <= direction_control & port_mask;
                analog_select_low_addr: reg_rdata <= analog_select_low;
                analog_select_high_addr: reg_rdata <= analog_select_high;
                osc_config_addr: reg_rdata <= {4'h0, osc_mode};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // pin_level_port_gpio

// File: core/pin_level_port_pkg.sv
/*
 * shared constants, register map and pin carrier types for the eight-pin
 * general-purpose port. assumes a simple strobe register port, one clock.
 */
package pin_level_port_pkg;

    localparam int unsigned port_width = 8;
    localparam int unsigned addr_width = 3;

    // register indices on the strobe port
    localparam logic [2:0] pin_level_port_addr = 3'h0;
    localparam logic [2:0] output_latch_addr = 3'h1;
    localparam logic [2:0] direction_control_addr = 3'h2;
    localparam logic [2:0] analog_select_low_addr = 3'h3;
    localparam logic [2:0] analog_select_high_addr = 3'h4;
    localparam logic [2:0] osc_config_addr = 3'h5;

    // values after reset
    localparam logic [7:0] output_latch_rst = 8'h00;
    localparam logic [7:0] direction_control_rst = 8'hff;
    localparam logic [7:0] analog_select_low_rst = 8'hff;
    localparam logic [7:0] analog_select_high_rst = 8'h01;
    localparam logic [3:0] osc_config_rst = 4'h7;

    // analog-capable pins and their select bit positions
    localparam logic [7:0] analog_pin_mask = 8'h3f;
    localparam logic [7:0] analog_low_used = 8'hff;
    localparam logic [7:0] analog_high_used = 8'h01;

    // capture / encoder pin positions
    localparam int unsigned cap_one_pin = 2;
    localparam int unsigned cap_two_pin = 3;
    localparam int unsigned cap_three_pin = 4;

    // cycle clock divide: four oscillator periods per cycle
    localparam logic [1:0] cycle_div_last = 2'h3;

    // main oscillator selection, 4-bit config field
    typedef enum logic [3:0] {
        osc_lp = 4'h0,
        osc_xt = 4'h1,
        osc_hs = 4'h2,
        rc_osc_mode = 4'h3,
        ext_clock_mode = 4'h4,
        ext_clock_with_io = 4'h5,
        osc_hs_pll = 4'h6,
        rc_osc_with_io = 4'h7,
        internal_osc_clkout = 4'h8,
        internal_osc_with_io = 4'h9
    } osc_mode_e;

    typedef struct packed {
        logic [7:0] pin_in;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
    } pad_s;

    typedef struct packed {
        logic capture_in_one;
        logic capture_in_two;
        logic capture_in_three;
        logic encoder_index_in;
        logic encoder_chan_a;
        logic encoder_chan_b;
    } periph_in_s;

endpackage

// File: dv/pin_level_port_gpio_sva.sv
/* port checker: pin drive, read data and oscillator pin use at the ports.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module pin_level_port_gpio_chk
    import pin_level_port_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic cycle_clock_out,
    input wire logic osc_pins_owned
);
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
logic osc_wr;
assign osc_wr = reg_wr && reg_addr == osc_config_addr;
//////////
chk_latch_drive: assert property (reg_wr && reg_addr <= output_latch_addr |=>
    pin_out[5:0] == $past(reg_wdata[5:0])) else $error("latch not on pins");
chk_dir_enable: assert property (reg_wr && reg_addr == direction_control_addr |=>
    pin_oe[5:0] == ~$past(reg_wdata[5:0])) else $error("enable not from direction");
chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
chk_latch_readback: assert property (reg_wr && reg_addr == output_latch_addr ##2
    reg_rd && reg_addr == output_latch_addr |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 3))
    else $error("latch read not latch value");
chk_unmapped_zero: assert property (reg_rd && reg_addr > osc_config_addr |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
chk_clock_pin: assert property (osc_wr && reg_wdata[3:0] inside {4'h3, 4'h4, 4'h8} |=>
    pin_oe[6] && pin_out[6] == cycle_clock_out) else $error("cycle clock not on pin");
chk_clock_rate: assert property ($rose(cycle_clock_out) |=> cycle_clock_out ##1
    !cycle_clock_out ##1 !cycle_clock_out ##1 cycle_clock_out) else $error("cycle clock rate");
chk_pin7_osc: assert property (osc_wr && reg_wdata[3:0] <= 4'h7 |=>
    !pin_oe[7] && osc_pins_owned) else $error("top pin driven in oscillator mode");
chk_full_port: assert property (osc_wr && reg_wdata[3:0] == 4'h9 |=> !osc_pins_owned)
    else $error("top pins not released to port");
cover property (osc_wr && reg_wdata[3:0] == 4'h8);
cover property (reg_rd && reg_addr == pin_level_port_addr);
cover property (reg_rd && reg_addr == 3'h7);
endmodule // pin_level_port_gpio_chk
bind pin_level_port_gpio pin_level_port_gpio_chk u_chk (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_out, .pin_oe, .cycle_clock_out, .osc_pins_owned);

// File: dv/tb.sv
/* self-checking bench for the eight-pin port: registers, pins, oscillator modes.
   assumes the port package and design are compiled first. */
`timescale 1ns/1ps
module tb
    import pin_level_port_pkg::*;
;
logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
logic [2:0] reg_addr = 3'h0;
logic [7:0] reg_wdata = 8'h00, board = 8'hff, pin_in, reg_rdata, pin_out, pin_oe;
periph_in_s periph_in;
logic cycle_clock_out, osc_pins_owned;
int fail_count = 0, checks_done = 0;
always #12.5 clk = ~clk;
// driven pins show the port's own value, the rest the board's
assign pin_in = (pin_out & pin_oe) | (board & ~pin_oe);
pin_level_port_gpio uut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in,
    .pin_out, .pin_oe, .periph_in, .cycle_clock_out, .osc_pins_owned);
//////////
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
endtask
task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
endtask
// four edges covers the two-flop synchroniser and the feed register
task automatic set_pins(input logic [7:0] v);
    @(posedge clk);
    board <= v;
    repeat (4) @(posedge clk);
    #1;
endtask
task automatic finish_test;
    $display("mismatches %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
//////////
task automatic t_reset;
    #1 chk(pin_oe, 8'h00);
    rd_chk(output_latch_addr, 8'h00);
    rd_chk(direction_control_addr, 8'h7f);
    rd_chk(analog_select_low_addr, 8'hff);
    rd_chk(analog_select_high_addr, 8'h01);
    rd_chk(pin_level_port_addr, 8'h40);
    chk({2'b00, periph_in}, 8'h00);
endtask
task automatic t_digital;
    wr(analog_select_low_addr, 8'h00);
    wr(direction_control_addr, 8'hcf);
    chk(pin_oe, 8'h30);
    wr(pin_level_port_addr, 8'h5a);
    chk({2'b00, pin_out[5:0]}, 8'h1a);
    set_pins(8'ha5);
    rd_chk(output_latch_addr, 8'h5a);
    rd_chk(pin_level_port_addr, 8'h15);
    chk({2'b00, periph_in}, 8'h2d);
endtask
task automatic t_analog;
    set_pins(8'hff);
    wr(analog_select_low_addr, 8'h14);
    chk({2'b00, pin_out[5:0]}, 8'h1a);
    chk(pin_oe, 8'h30);
    rd_chk(analog_select_low_addr, 8'h14);
    rd_chk(pin_level_port_addr, 8'h4b);
    chk({2'b00, periph_in}, 8'h12);
endtask
task automatic t_osc;
    logic clk_mode, io6;
    wr(direction_control_addr, 8'h40);
    wr(output_latch_addr, 8'hff);
    rd_chk(output_latch_addr, 8'h7f);
    for (int m = 0; m < 10; m++) begin
        wr(osc_config_addr, 8'(m));
        clk_mode = m inside {3, 4, 8};
        io6 = m inside {5, 7, 9};
        chk({7'h00, osc_pins_owned}, {7'h00, m != 9});
        chk({7'h00, pin_oe[7]}, {7'h00, m > 7});
        if (clk_mode || io6) chk({7'h00, pin_oe[6]}, {7'h00, clk_mode});
        rd_chk(output_latch_addr, {m > 7, io6, 6'h3f});
        rd_chk(direction_control_addr, {1'b0, io6, 6'h00});
    end
    // codes past the last mode leave the full-port mode in place
    wr(osc_config_addr, 8'h0c);
    chk({7'h00, osc_pins_owned}, 8'h00);
endtask
task automatic t_unmapped;
    wr(3'h6, 8'h00);
    rd_chk(3'h6, 8'h00);
    rd_chk(3'h7, 8'h00);
    rd_chk(output_latch_addr, 8'hff);
endtask
//////////
initial begin
    #200us;
    fail_count++;
    finish_test;
end
initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_digital;
    t_analog;
    t_osc;
    t_unmapped;
    finish_test;
end
endmodule // tb
